// *** spo_pin_override.sv ***
// Serial clock and transmit pin override with AHB-Lite register access
`timescale 1ns/10ps

// Behaviour
// [R01] Async, source 00: port bits control clock pin
// [R02] Internal clock drives pin when selected
// [R03] Source 10 selects external clock; 11 prohibited
// [R04] Clock level read returns clock pin
// [R05] Break direction set drives transmit pin level
// [R06] Break direction clear leaves transmit pin input
// [R07] Break level read returns receive pin
// [R08] Both level bits store zero at reset
// [R09] Software assigns pin functions first
// [R10] Transmit enable hands pin to core
module spo_pin_override (
   input  wire logic        core_clk,     // System clock, 50 MHz
   input  wire logic        rstn,         // Asynchronous reset, active low
   input  wire logic        clkEn,        // Clock enable, freezes state when low
   input  wire logic        hsel,         // AHB slave select
   input  wire logic [31:0] haddr,        // AHB address
   input  wire logic [1:0]  htrans,       // AHB transfer type
   input  wire logic        hwrite,       // AHB write
   input  wire logic [2:0]  hsize,        // AHB size, word only
   input  wire logic [31:0] hwdata,       // AHB write data
   input  wire logic        hready,       // AHB bus ready
   output logic      [31:0] hrdata,       // AHB read data
   output logic             hreadyout,    // AHB slave ready
   output logic             hresp,        // AHB response, always OKAY
   input  wire logic        sckIn,        // Serial clock pin level
   output logic             sckOut,       // Serial clock pin drive value
   output logic             sckOe,        // Serial clock pin drive enable
   input  wire logic        txdIn,        // Transmit pin level, not monitored
   output logic             txdOut,       // Transmit pin drive value
   output logic             txdOe,        // Transmit pin drive enable
   input  wire logic        rxdIn,        // Receive pin level
   input  wire logic        coreSclk,     // Internal serial clock from core
   input  wire logic        coreTxd,      // Transmit data from core
   output logic             extClkSel,    // Core runs on external clock
   output logic             extClkLevel,  // Synchronised clock pin level
   output logic             extClkRise    // Rising edge of clock pin in external clock mode, one cycle
);

   // Clock pin function
   typedef enum {CLK_PORT, CLK_INT_OUT, CLK_EXT_IN, CLK_BAD} spo_clk_mode_t;

   // Software-visible registers
   spo_pkg::spo_ctrl_t ctrl_reg;
   spo_pkg::spo_ctrl_t ctrl_next;
   spo_pkg::spo_port_t port_reg;
   spo_pkg::spo_port_t port_next;

   // Bus capture between address and data phase
   logic               wrPend_reg;
   logic               wrPend_next;
   logic [7:0]         wrAddr_reg;
   logic [7:0]         wrAddr_next;

   // Read data, held through the data phase
   logic [31:0]        rdData_reg;
   logic [31:0]        rdData_next;

   // Synchronisers for the asynchronous pin levels
   logic [spo_pkg::SPO_SYNC_STAGES-1:0] sckSync_reg;
   logic [spo_pkg::SPO_SYNC_STAGES-1:0] sckSync_next;
   logic [spo_pkg::SPO_SYNC_STAGES-1:0] rxdSync_reg;
   logic [spo_pkg::SPO_SYNC_STAGES-1:0] rxdSync_next;

   // Clock pin edge finder
   logic               sckPrev_reg;
   logic               sckPrev_next;
   logic               rise_reg;
   logic               rise_next;

   // Registered pin drives
   spo_pkg::spo_pin_t  sck_reg;
   spo_pkg::spo_pin_t  sck_next;
   spo_pkg::spo_pin_t  txd_reg;
   spo_pkg::spo_pin_t  txd_next;

   // Decoded values
   spo_clk_mode_t      clkMode;
   logic               addrPhase;
   logic [7:0]         addrLow;
   logic               sckLevel;
   logic               rxdLevel;

   // Timing at a glance
   // Write lands at the edge that ends its data phase
   // Pin drive follows one edge later, glitch-free from flops
   // Pin reads pass the synchroniser before the read mux
   // Core clock and data reach the pins one cycle late
   // Prohibited source code leaves the clock pin undriven

   // Bus handshake, never waits, never errors
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdData_reg;

   // Address phase decode
   assign addrPhase = hsel & htrans[1] & hready;
   assign addrLow   = haddr[7:0];

   // Pin levels after the second synchroniser stage
   assign sckLevel = sckSync_reg[spo_pkg::SPO_SYNC_STAGES-1];
   assign rxdLevel = rxdSync_reg[spo_pkg::SPO_SYNC_STAGES-1];

   // Clock pin function from mode and clock-source bits
   always_comb begin
      unique case ({ctrl_reg.clockSourceHi, ctrl_reg.clockSourceLo})
         2'b00: begin
            if (ctrl_reg.syncMode) begin
               clkMode = CLK_INT_OUT; // R02
            end else begin
               clkMode = CLK_PORT; // R01
            end
         end
         2'b01: clkMode = CLK_INT_OUT; // R02
         2'b10: clkMode = CLK_EXT_IN; // R03
         2'b11: clkMode = CLK_BAD; // R03
      endcase
   end

   // Bus capture, remembers a write's address for its data phase
   always_comb begin
      wrPend_next = 1'b0;
      wrAddr_next = wrAddr_reg;
      if (addrPhase) begin
         wrPend_next = hwrite;
         wrAddr_next = {addrLow[7:2], 2'b00};
      end
   end

   // Bus capture flops
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wrPend_reg <= 1'b0;
         wrAddr_reg <= 8'h00;
      end else if (clkEn) begin
         wrPend_reg <= wrPend_next;
         wrAddr_reg <= wrAddr_next;
      end
   end

   // Register update in the data phase of a write
   always_comb begin
      ctrl_next = ctrl_reg;
      port_next = port_reg;
      if (wrPend_reg) begin
         if (wrAddr_reg == spo_pkg::SPO_CTRL_OFS) begin
            ctrl_next = spo_pkg::spo_ctrl_t'(hwdata[3:0]);
         end else if (wrAddr_reg == spo_pkg::SPO_PORT_OFS) begin
            port_next = spo_pkg::spo_port_t'(hwdata[3:0]);
         end
      end
   end

   // Register flops, stored levels zero after reset
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_reg <= spo_pkg::spo_ctrl_t'(spo_pkg::SPO_CTRL_RST);
         port_reg <= spo_pkg::spo_port_t'(spo_pkg::SPO_PORT_RST); // R08
      end else if (clkEn) begin
         ctrl_reg <= ctrl_next;
         port_reg <= port_next;
      end
   end

   // Read mux, sees a write landing in the same cycle
   always_comb begin
      rdData_next = rdData_reg;
      if (addrPhase && !hwrite) begin
         rdData_next = 32'h0000_0000;
         if (addrLow[7:2] == spo_pkg::SPO_CTRL_OFS[7:2]) begin
            rdData_next[3:0] = ctrl_next;
         end else if (addrLow[7:2] == spo_pkg::SPO_PORT_OFS[7:2]) begin
            rdData_next[spo_pkg::SPO_PORT_CKDIR_BIT]  = port_next.clockPortDirection;
            rdData_next[spo_pkg::SPO_PORT_CKLVL_BIT]  = sckLevel; // R04
            rdData_next[spo_pkg::SPO_PORT_BRKDIR_BIT] = port_next.breakPortDirection;
            rdData_next[spo_pkg::SPO_PORT_BRKLVL_BIT] = rxdLevel; // R07
         end
      end
   end

   // Read data flops
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rdData_reg <= 32'h0000_0000;
      end else if (clkEn) begin
         rdData_reg <= rdData_next;
      end
   end

   // Pin synchronisers, only the last stage is read
   always_comb begin
      sckSync_next = {sckSync_reg[spo_pkg::SPO_SYNC_STAGES-2:0], sckIn};
      rxdSync_next = {rxdSync_reg[spo_pkg::SPO_SYNC_STAGES-2:0], rxdIn};
   end

   // Synchroniser flops
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         sckSync_reg <= '0;
         rxdSync_reg <= '0;
      end else if (clkEn) begin
         sckSync_reg <= sckSync_next;
         rxdSync_reg <= rxdSync_next;
      end
   end

   // Clock pin edge finder, gated to external clock mode
   always_comb begin
      sckPrev_next = sckLevel;
      rise_next    = sckLevel & ~sckPrev_reg & (clkMode == CLK_EXT_IN); // R03
   end

   // Edge finder flops
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         sckPrev_reg <= 1'b0;
         rise_reg    <= 1'b0;
      end else if (clkEn) begin
         sckPrev_reg <= sckPrev_next;
         rise_reg    <= rise_next;
      end
   end

   // External clock hand-off to the serial core
   assign extClkSel   = (clkMode == CLK_EXT_IN); // R03
   assign extClkLevel = sckLevel;
   assign extClkRise  = rise_reg;

   // Pin drive selection
   always_comb begin
      sck_next = '{out: 1'b0, oe: 1'b0};
      unique case (clkMode)
         CLK_PORT: begin
            sck_next.oe  = port_reg.clockPortDirection; // R01
            sck_next.out = port_reg.clockPortLevel; // R01
         end
         CLK_INT_OUT: begin
            sck_next.oe  = 1'b1; // R02
            sck_next.out = coreSclk; // R02
         end
         CLK_EXT_IN: sck_next = '{out: 1'b0, oe: 1'b0}; // R03
         CLK_BAD:    sck_next = '{out: 1'b0, oe: 1'b0}; // R03
      endcase
   end

   // Clock pin drive flops, undriven after reset
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         sck_reg <= '{out: 1'b0, oe: 1'b0};
      end else if (clkEn) begin
         sck_reg <= sck_next;
      end
   end

   // Transmit pin drive selection, core first, then break
   always_comb begin
      if (ctrl_reg.txEnable) begin
         txd_next = '{out: coreTxd, oe: 1'b1}; // R10
      end else if (port_reg.breakPortDirection) begin
         txd_next = '{out: port_reg.breakPortLevel, oe: 1'b1}; // R05
      end else begin
         txd_next = '{out: 1'b0, oe: 1'b0}; // R06
      end
   end

   // Transmit pin drive flops, input after reset
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         txd_reg <= '{out: 1'b0, oe: 1'b0}; // R06
      end else if (clkEn) begin
         txd_reg <= txd_next;
      end
   end

   // Pin outputs
   assign sckOut = sck_reg.out;
   assign sckOe  = sck_reg.oe;
   assign txdOut = txd_reg.out;
   assign txdOe  = txd_reg.oe;

endmodule // spo_pin_override

// *** spo_pkg.sv ***
// Package: register map, field positions and carrier types for the serial pin override
package spo_pkg;

   // Register word offsets (byte addresses)
   localparam logic [7:0] SPO_CTRL_OFS = 8'h00;
   localparam logic [7:0] SPO_PORT_OFS = 8'h04;

   // Control register field positions
   localparam int SPO_CTRL_SYNC_BIT = 0;
   localparam int SPO_CTRL_CKLO_BIT = 1;
   localparam int SPO_CTRL_CKHI_BIT = 2;
   localparam int SPO_CTRL_TXEN_BIT = 3;

   // Port register field positions
   localparam int SPO_PORT_BRKLVL_BIT = 0;
   localparam int SPO_PORT_BRKDIR_BIT = 1;
   localparam int SPO_PORT_CKLVL_BIT  = 2;
   localparam int SPO_PORT_CKDIR_BIT  = 3;

   // Reset values
   localparam logic [3:0] SPO_CTRL_RST = 4'h0;
   localparam logic [3:0] SPO_PORT_RST = 4'h0;

   // Synchroniser depth for pin inputs
   localparam int SPO_SYNC_STAGES = 2;

   // Control fields
   typedef struct packed {
      logic txEnable;
      logic clockSourceHi;
      logic clockSourceLo;
      logic syncMode;
   } spo_ctrl_t;

   // Port fields, laid out as in the port register
   typedef struct packed {
      logic clockPortDirection;
      logic clockPortLevel;
      logic breakPortDirection;
      logic breakPortLevel;
   } spo_port_t;

   // Drive of one two-way pin
   typedef struct packed {
      logic out;
      logic oe;
   } spo_pin_t;

endpackage

// *** spo_pin_override_chk.sv ***
// Port checker for the serial pin override
`timescale 1ns/10ps
module spo_pin_override_chk (
   input wire logic        core_clk,  // Clock
   input wire logic        rstn,      // Reset
   input wire logic        clkEn,     // Clock enable
   input wire logic        hsel,      // Select
   input wire logic [31:0] haddr,     // Address
   input wire logic [1:0]  htrans,    // Transfer
   input wire logic        hwrite,    // Write
   input wire logic [31:0] hwdata,    // Data
   input wire logic        hready,    // Ready
   input wire logic        coreSclk,  // Core clock
   input wire logic        coreTxd,   // Core data
   input wire logic        sckOut,    // Clock drive
   input wire logic        sckOe,     // Clock enable
   input wire logic        txdOut,    // Tx drive
   input wire logic        txdOe,     // Tx enable
   input wire logic        extClkSel  // Ext clock
);
   logic [3:0] ctlReg, ctlNext, portReg, portNext;
   logic [7:0] adrReg, adrNext;
   logic       wrReg, wrNext;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn || !clkEn);
   // Mirror of the two registers
   always_comb begin
      wrNext = hsel && htrans[1] && hready && hwrite;
      adrNext = haddr[7:0];
      ctlNext = (wrReg && adrReg == spo_pkg::SPO_CTRL_OFS) ? hwdata[3:0] : ctlReg;
      portNext = (wrReg && adrReg == spo_pkg::SPO_PORT_OFS) ? hwdata[3:0] : portReg;
   end
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) {wrReg, adrReg, ctlReg, portReg} <= '0;
      else if (clkEn) {wrReg, adrReg, ctlReg, portReg} <= {wrNext, adrNext, ctlNext, portNext};
   end
   AST_CK_PORT: assert property (ctlReg[2:0] == 3'h0 |=> sckOe == $past(portReg[3]))
      else $error("clock pin direction wrong");
   AST_CK_LVL: assert property (ctlReg[2:0] == 3'h0 && portReg[3] |=> sckOut == $past(portReg[2]))
      else $error("clock pin level wrong");
   AST_CK_INT: assert property ((ctlReg[2:0] == 3'h2 || (ctlReg[0] && !ctlReg[2]))
      |=> sckOe && sckOut == $past(coreSclk)) else $error("internal clock not driven");
   AST_CK_EXT: assert property (ctlReg[2:1] == 2'h2 |-> extClkSel ##1 !sckOe)
      else $error("external clock not selected");
   AST_NO_EXT: assert property (ctlReg[2:1] != 2'h2 |-> !extClkSel)
      else $error("external clock selected wrongly");
   AST_TX_BRK: assert property (!ctlReg[3] && portReg[1] |=> txdOe && txdOut == $past(portReg[0]))
      else $error("break level not driven");
   AST_TX_IN: assert property (!ctlReg[3] && !portReg[1] |=> !txdOe)
      else $error("transmit pin driven");
   AST_TX_CORE: assert property (ctlReg[3] |=> txdOe && txdOut == $past(coreTxd))
      else $error("core data not driven");
endmodule // spo_pin_override_chk
bind spo_pin_override spo_pin_override_chk chk (.core_clk, .rstn, .clkEn, .hsel, .haddr,
   .htrans, .hwrite,
   .hwdata, .hready, .coreSclk, .coreTxd, .sckOut, .sckOe, .txdOut, .txdOe, .extClkSel);

// *** spo_far_dev.sv ***
// Far-side serial device model
`timescale 1ns/10ps
module spo_far_dev (
   input wire logic run,     // Link clock on
   input wire logic sckOut,  // Clock drive
   input wire logic sckOe,   // Clock enable
   input wire logic txdOut,  // Tx drive
   input wire logic txdOe,   // Tx enable
   input wire logic rxdLvl,  // Rx level
   output logic     sckIn,   // Clock wire
   output logic     txdIn,   // Tx wire
   output logic     rxdIn    // Rx wire
);
   logic lnkClk = 1'b1;
   // Link clock, still high between frames
   always #80 lnkClk = run ? ~lnkClk : 1'b1;
   // Wire levels: when undriven, the clock wire follows the link clock and the transmit wire is pulled up
   assign sckIn = sckOe ? sckOut : lnkClk;
   assign txdIn = txdOe ? txdOut : 1'b1;
   assign rxdIn = rxdLvl;
endmodule // spo_far_dev

// *** test_spo_pin_override.sv ***
// Testbench for the serial pin override
`timescale 1ns/10ps
module test_spo_pin_override;
   logic        core_clk = 1'b0, rstn = 1'b0, hwrite = 1'b0, coreSclk = 1'b0;
   logic        run = 1'b0, rxdLvl = 1'b1, coreTxd = 1'b0, clkEn = 1'b1;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic        hreadyout, hresp, sckIn, sckOut, sckOe, txdIn, txdOut, txdOe, rxdIn;
   logic        extClkSel, extClkLevel, extClkRise;
   logic [3:0]  m;
   int          errors = 0, n_compared = 0, rises;
   spo_pin_override dut (.core_clk, .rstn, .clkEn, .hsel(1'b1), .haddr, .htrans,
      .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
      .sckIn, .sckOut, .sckOe, .txdIn, .txdOut, .txdOe, .rxdIn, .coreSclk, .coreTxd,
      .extClkSel, .extClkLevel, .extClkRise);
   spo_far_dev far (.run, .sckOut, .sckOe, .txdOut, .txdOe, .rxdLvl, .sckIn, .txdIn, .rxdIn);
   initial forever #10 core_clk = ~core_clk;
   always @(posedge core_clk) coreSclk <= ~coreSclk;
   task automatic give_verdict;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic waitRdy;
      int i;
      @(posedge core_clk);
      for (i = 0; hreadyout !== 1'b1 && i < 50; i++) @(posedge core_clk);
      if (i == 50) begin
         errors++;
         give_verdict();
      end
   endtask
   // One single-word transfer, read data into rd
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      hwrite <= w;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      waitRdy();
      htrans <= 2'h0;
      hwdata <= d;
      waitRdy();
      rd = hrdata;
      chk({31'h0, hresp}, 32'h0);
   endtask
   // Write the port register, then check {sckOe, sckOut, txdOe, txdOut}
   task automatic pin(input logic [3:0] v, input logic [3:0] exp);
      xfer(1'b1, 8'h04, {28'h0, v});
      repeat (3) @(posedge core_clk);
      #1 chk({28'h0, sckOe, sckOut, txdOe, txdOut}, {28'h0, exp});
      @(posedge core_clk);
   endtask
   // Pin functions assumed assigned to this port beforehand
   initial begin
      repeat (8) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      xfer(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h0);
      pin(4'h0, 4'h0);
      pin(4'h8, 4'h8);
      xfer(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h9);
      pin(4'hC, 4'hC);
      pin(4'h2, 4'h2);
      pin(4'h3, 4'h3);
      xfer(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h7);
      rxdLvl <= 1'b0;
      repeat (4) @(posedge core_clk);
      xfer(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h6);
      chk({31'h0, extClkLevel}, 32'h1);
      xfer(1'b1, 8'h00, 32'h8);
      pin(4'h3, 4'h2);
      $display("pin override tests done");
      pin(4'hC, 4'hE);
      for (int k = 0; k < 7; k++) begin
         m = 4'(k + 1);
         run <= m[2];
         xfer(1'b1, 8'h00, {28'h0, m});
         rises = 0;
         repeat (80) @(posedge core_clk) rises += int'(extClkRise === 1'b1);
         #1 chk({sckOe, extClkSel, rises > 5}, m[2] ? {1'b0, {2{!m[1]}}} : 3'b1_00);
         if (!m[2]) chk({31'h0, sckOut}, {31'h0, ~coreSclk});
         @(posedge core_clk);
      end
      run <= 1'b0;
      $display("clock source tests done");
      xfer(1'b1, 8'h10, 32'hF);
      xfer(1'b0, 8'h10, 32'h0);
      chk(rd, 32'h0);
      xfer(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h7);
      clkEn <= 1'b0;
      xfer(1'b1, 8'h00, 32'h0);
      clkEn <= 1'b1;
      xfer(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h7);
      $display("register tests done");
      give_verdict();
   end
endmodule // test_spo_pin_override
